// >>> core/vbr_regs.sv
// voltmeter backplane register bank: read/write registers, interrupts, triggers
//
// Behaviour
// - read 0 returns eight-bit identification code
// - read 1 returns status, bit 7 zero
// - result-available sets on load, clears on ack
// - new results may load while flag set
// - busy sets on command/parameter write, clears done
// - conversion-complete sets on run-up, cleared by ack
// - error flag set, data holds error code
// - done clears on write, sets on completion
// - aperiodic flag, forced with autorange plus multi-read
// - read 2 high word, read 3 low
// - control register uses low four bits only
// - control bit 0 masters all interrupts
// - control bit 1 resets, done within 500us; busy stays set past the tail until a command completes
// - control bit 2 picks interrupt line
// - control bit 3 adds conversion-complete source
// - trigger bit 0 gates all triggers
// - trigger bit 1 picks trigger edge/line
// - write 2 takes command words
// - write 3 clears result-available interrupt
// - write 6 takes parameter words
// - write 7 clears conversion-complete interrupt
`timescale 1ns/1ns
module vbr_regs
  import vbr_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5A, // arbitrary identification value
  parameter int RST_CYCLES = VBR_RST_CYC
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // backplane register access
  input wire logic RD_I,
  input wire logic WR_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  output logic [15:0] RDATA_O,
  // backplane interrupt and trigger lines
  output logic GENERAL_PURPOSE_IRQ_LINE_O,
  output logic NORMAL_SCAN_IRQ_LINE_O,
  input wire logic TRIG_I,
  input wire logic CHANNEL_CLOSED_LINE_I,
  // measurement core side
  input wire vbr_core_ev_t CORE_EV_I,
  input wire logic AUTORANGE_I,
  input wire logic MULTI_READ_I,
  output logic TRIGGER_O,
  output logic CMD_STB_O,
  output logic [15:0] CMD_O,
  output logic PARAM_STB_O,
  output logic [15:0] PARAM_O,
  output logic CORE_RST_O
);
  // refuse a tail length the counter cannot count down from
  if (RST_CYCLES < 1) begin : g_bad_rst_cycles
    $error("RST_CYCLES must be at least one");
  end

  localparam int RCW = $clog2(RST_CYCLES + 1);

  logic [3:0] ctrl;
  logic [1:0] trig_cfg;
  logic [31:0] data_word;
  vbr_status_t status;
  logic [RCW-1:0] rst_cnt;
  logic trig_q;
  logic closed_q;
  logic wr_cmd;
  logic wr_param;
  logic wr_res_ack;
  logic wr_conv_ack;
  logic rst_active;
  logic next_trigger;
  logic next_gen_line;
  logic next_scan_line;
  logic irq_req;

  ////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_cmd = WR_I && (ADDR_I == VBR_A_CMD);
  assign wr_param = WR_I && (ADDR_I == VBR_A_PARAM);
  assign wr_res_ack = WR_I && (ADDR_I == VBR_A_RES_ACK);
  assign wr_conv_ack = WR_I && (ADDR_I == VBR_A_CONV_ACK);
  assign rst_active = ctrl[VBR_C_SOFT_RST] || (rst_cnt != '0);

  // control register keeps the low nibble only
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl <= VBR_CTRL_RST;
    end else if (WR_I && ADDR_I == VBR_A_CTRL) begin
      ctrl <= WDATA_I[3:0];
    end
  end

  // trigger setup
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      trig_cfg <= VBR_TRIG_RST;
    end else if (WR_I && ADDR_I == VBR_A_TRIG) begin
      trig_cfg <= WDATA_I[1:0];
    end
  end

  // command and parameter words pass to the core with a strobe
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CMD_O <= VBR_WORD_RST;
      PARAM_O <= VBR_WORD_RST;
      CMD_STB_O <= 1'b0;
      PARAM_STB_O <= 1'b0;
    end else begin
      CMD_STB_O <= wr_cmd;
      PARAM_STB_O <= wr_param;
      if (wr_cmd) begin
        CMD_O <= WDATA_I;
      end
      if (wr_param) begin
        PARAM_O <= WDATA_I;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // soft reset: held while bit set, then a timed tail
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_cnt <= '0;
      CORE_RST_O <= 1'b0;
    end else begin
      if (ctrl[VBR_C_SOFT_RST]) begin
        rst_cnt <= RCW'(RST_CYCLES - 1);
      end else if (rst_cnt != '0) begin
        rst_cnt <= rst_cnt - 1'b1;
      end
      CORE_RST_O <= rst_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result / error data; loads are never blocked by the flag
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      data_word <= 32'h00000000;
    end else if (CORE_EV_I.error_load) begin
      data_word <= CORE_EV_I.error_code;
    end else if (CORE_EV_I.result_load) begin
      data_word <= CORE_EV_I.result;
    end
  end

  // status flags; a set in the same cycle as a clear wins, except done, where a command or parameter write's clear wins over completion
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      status <= '0;
    end else if (rst_active) begin
      // soft reset clears flags and sets busy, which holds past the tail until a command completes
      status <= '0;
      status.busy <= 1'b1;
    end else begin
      status.unused7 <= 1'b0;
      status.spare5 <= 1'b0;
      if (CORE_EV_I.result_load || CORE_EV_I.error_load) begin
        status.result_avail <= 1'b1;
      end else if (wr_res_ack) begin
        status.result_avail <= 1'b0;
      end
      if (CORE_EV_I.conv_done) begin
        status.conv_done <= 1'b1;
      end else if (wr_conv_ack) begin
        status.conv_done <= 1'b0;
      end
      if (CORE_EV_I.error_load) begin
        status.error <= 1'b1;
      end else if (CORE_EV_I.result_load) begin
        status.error <= 1'b0;
      end
      if (wr_cmd || wr_param) begin
        status.busy <= 1'b1;
        status.done <= 1'b0;
      end else if (CORE_EV_I.cmd_complete) begin
        status.busy <= 1'b0;
        status.done <= 1'b1;
      end else if (status.busy && !status.done && rst_cnt == '0 && !CMD_STB_O) begin
        // busy left from soft reset holds past the reset tail until a command completes
        status.busy <= status.busy;
      end
      status.aperiodic <= CORE_EV_I.aperiodic ||
                          (AUTORANGE_I && MULTI_READ_I);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered; unused addresses read zero
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= VBR_WORD_RST;
    end else if (RD_I) begin
      unique case (ADDR_I)
        VBR_A_ID: RDATA_O <= {8'h00, ID_CODE};
        VBR_A_STATUS: RDATA_O <= {8'h00, status};
        VBR_A_RES_HI: RDATA_O <= data_word[31:16];
        VBR_A_RES_LO: RDATA_O <= data_word[15:0];
        default: RDATA_O <= VBR_WORD_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt routing
  always_comb begin
    irq_req = status.result_avail || (ctrl[VBR_C_SRC_SEL] && status.conv_done);
    irq_req = irq_req && ctrl[VBR_C_IRQ_EN] && !rst_active;
    next_gen_line = irq_req && !ctrl[VBR_C_LINE_SEL];
    next_scan_line = irq_req && ctrl[VBR_C_LINE_SEL];
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      GENERAL_PURPOSE_IRQ_LINE_O <= 1'b0;
      NORMAL_SCAN_IRQ_LINE_O <= 1'b0;
    end else begin
      GENERAL_PURPOSE_IRQ_LINE_O <= next_gen_line;
      NORMAL_SCAN_IRQ_LINE_O <= next_scan_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger edge detect; lines already synchronous
  always_comb begin
    if (trig_cfg[VBR_T_EDGE_SEL]) begin
      next_trigger = trig_q && !TRIG_I;
    end else begin
      next_trigger = !closed_q && CHANNEL_CLOSED_LINE_I;
    end
    next_trigger = next_trigger && trig_cfg[VBR_T_ENABLE] && !rst_active;
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      trig_q <= 1'b0;
      closed_q <= 1'b0;
      TRIGGER_O <= 1'b0;
    end else begin
      trig_q <= TRIG_I;
      closed_q <= CHANNEL_CLOSED_LINE_I;
      TRIGGER_O <= next_trigger;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks; each |=> property samples one edge and judges the next
  // outputs are registered, so an effect always shows one edge late

  // command and parameter words toward the core, busy/done on those writes, done on completion, control nibble
  a_busy_on_cmd: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (wr_cmd || wr_param) |=> status.busy && !status.done)
    else $error("busy/done not updated on command write");
  a_done_on_cmplt: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (CORE_EV_I.cmd_complete && !wr_cmd && !wr_param && !rst_active) |=> status.done)
    else $error("done not set on completion");
  a_cmd_strobe: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_cmd |=> CMD_STB_O && (CMD_O == $past(WDATA_I)))
    else $error("command word not passed on");
  a_param_strobe: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_param |=> PARAM_STB_O && (PARAM_O == $past(WDATA_I)))
    else $error("parameter word not passed on");
  a_ctrl_nibble: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (WR_I && ADDR_I == VBR_A_CTRL) |=> ctrl == $past(WDATA_I[3:0]))
    else $error("control nibble not taken");

  // status flags; a load in the same cycle as an ack wins
  a_result_flag: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (CORE_EV_I.result_load && !rst_active) |=> status.result_avail)
    else $error("result flag lost");
  a_result_ack: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (wr_res_ack && !CORE_EV_I.result_load && !CORE_EV_I.error_load) |=> !status.result_avail)
    else $error("result ack ignored");
  a_result_load: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (CORE_EV_I.result_load && !CORE_EV_I.error_load) |=> data_word == $past(CORE_EV_I.result))
    else $error("result not loaded");
  a_conv_flag: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (CORE_EV_I.conv_done && !rst_active) |=> status.conv_done)
    else $error("conversion flag lost");
  a_conv_ack: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (wr_conv_ack && !CORE_EV_I.conv_done) |=> !status.conv_done)
    else $error("conversion ack ignored");
  a_error_flag: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (CORE_EV_I.error_load && !rst_active) |=> status.error)
    else $error("error flag lost");
  a_error_code: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    CORE_EV_I.error_load |=> data_word == $past(CORE_EV_I.error_code))
    else $error("error code not loaded");
  a_aperiodic_pair: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (AUTORANGE_I && MULTI_READ_I && !rst_active) |=> status.aperiodic)
    else $error("aperiodic flag not forced");

  // read data, one cycle after the request
  a_id_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (RD_I && ADDR_I == VBR_A_ID) |=> RDATA_O == {8'h00, ID_CODE})
    else $error("identification read mismatch");
  a_status_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (RD_I && ADDR_I == VBR_A_STATUS) |=> RDATA_O == {8'h00, $past(status)})
    else $error("status read mismatch");
  a_status_top: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (RD_I && ADDR_I == VBR_A_STATUS) |=> RDATA_O[15:7] == 9'h000)
    else $error("status upper bits not zero");
  a_hi_word: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (RD_I && ADDR_I == VBR_A_RES_HI) |=> RDATA_O == $past(data_word[31:16]))
    else $error("high word mismatch");
  a_lo_word: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (RD_I && ADDR_I == VBR_A_RES_LO) |=> RDATA_O == $past(data_word[15:0]))
    else $error("low word mismatch");

  // interrupt lines
  a_irq_master: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !$past(ctrl[VBR_C_IRQ_EN]) |-> !GENERAL_PURPOSE_IRQ_LINE_O && !NORMAL_SCAN_IRQ_LINE_O)
    else $error("interrupt while disabled");
  a_irq_line: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !(GENERAL_PURPOSE_IRQ_LINE_O && NORMAL_SCAN_IRQ_LINE_O))
    else $error("both interrupt lines active");
  a_irq_result: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ctrl[VBR_C_IRQ_EN] && !ctrl[VBR_C_LINE_SEL] && status.result_avail && !rst_active)
    |=> GENERAL_PURPOSE_IRQ_LINE_O)
    else $error("result interrupt missing");
  a_irq_source: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (!ctrl[VBR_C_SRC_SEL] && !status.result_avail)
    |=> !GENERAL_PURPOSE_IRQ_LINE_O && !NORMAL_SCAN_IRQ_LINE_O)
    else $error("interrupt from unselected source");
  a_irq_conv: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ctrl[VBR_C_IRQ_EN] && ctrl[VBR_C_SRC_SEL] && ctrl[VBR_C_LINE_SEL] && status.conv_done &&
    !rst_active) |=> NORMAL_SCAN_IRQ_LINE_O)
    else $error("conversion interrupt missing");

  // soft reset
  a_rst_tail: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $fell(ctrl[VBR_C_SOFT_RST]) |-> rst_cnt == RCW'(RST_CYCLES - 1))
    else $error("reset tail not loaded");
  a_rst_count: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (!ctrl[VBR_C_SOFT_RST] && rst_cnt != '0) |=> rst_cnt == $past(rst_cnt) - 1'b1)
    else $error("reset tail not counting");
  a_core_rst: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    rst_active |=> CORE_RST_O)
    else $error("core reset not driven");
  a_rst_busy: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    rst_active |=> status.busy)
    else $error("busy not shown during reset");

  // cycles since the soft reset bit dropped; bounds the tail length
  logic [RCW:0] tail_age;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tail_age <= '0;
    end else if (ctrl[VBR_C_SOFT_RST] || !rst_active) begin
      tail_age <= '0;
    end else begin
      tail_age <= tail_age + 1'b1;
    end
  end
  a_rst_within: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    tail_age <= (RCW + 1)'(RST_CYCLES))
    else $error("reset tail too long");

  // triggers
  a_trig_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !$past(trig_cfg[VBR_T_ENABLE]) |-> !TRIGGER_O)
    else $error("trigger while disabled");
  a_trig_fall: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (trig_cfg[VBR_T_ENABLE] && trig_cfg[VBR_T_EDGE_SEL] && trig_q && !TRIG_I && !rst_active)
    |=> TRIGGER_O)
    else $error("falling trigger missed");
  a_trig_close: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (trig_cfg[VBR_T_ENABLE] && !trig_cfg[VBR_T_EDGE_SEL] && !closed_q && CHANNEL_CLOSED_LINE_I &&
    !rst_active) |=> TRIGGER_O)
    else $error("channel-closed trigger missed");
endmodule

// >>> core/vbr_pkg.sv
// constants and types for the voltmeter backplane register bank
package vbr_pkg;
  // register addresses (read and write share numbers)
  localparam logic [2:0] VBR_A_ID = 3'h0;
  localparam logic [2:0] VBR_A_STATUS = 3'h1;
  localparam logic [2:0] VBR_A_RES_HI = 3'h2;
  localparam logic [2:0] VBR_A_RES_LO = 3'h3;
  localparam logic [2:0] VBR_A_CTRL = 3'h0;
  localparam logic [2:0] VBR_A_TRIG = 3'h1;
  localparam logic [2:0] VBR_A_CMD = 3'h2;
  localparam logic [2:0] VBR_A_RES_ACK = 3'h3;
  localparam logic [2:0] VBR_A_PARAM = 3'h6;
  localparam logic [2:0] VBR_A_CONV_ACK = 3'h7;
  // control field positions
  localparam int VBR_C_IRQ_EN = 0;
  localparam int VBR_C_SOFT_RST = 1;
  localparam int VBR_C_LINE_SEL = 2;
  localparam int VBR_C_SRC_SEL = 3;
  localparam int VBR_T_ENABLE = 0;
  localparam int VBR_T_EDGE_SEL = 1;
  // reset values
  localparam logic [3:0] VBR_CTRL_RST = 4'h0;
  localparam logic [1:0] VBR_TRIG_RST = 2'h0;
  localparam logic [15:0] VBR_WORD_RST = 16'h0000;
  // reset completion time
  localparam int VBR_CLK_MHZ = 25;
  localparam int VBR_RST_TIME_US = 500;
  localparam int VBR_RST_CYC = VBR_RST_TIME_US * VBR_CLK_MHZ;
  // status word layout, bit 7 first
  typedef struct packed {
    logic unused7;
    logic aperiodic;
    logic spare5;
    logic done;
    logic error;
    logic conv_done;
    logic busy;
    logic result_avail;
  } vbr_status_t;
  // events from the measurement core
  typedef struct packed {
    logic result_load;
    logic [31:0] result;
    logic error_load;
    logic [31:0] error_code;
    logic conv_done;
    logic cmd_complete;
    logic aperiodic;
  } vbr_core_ev_t;
endpackage

// >>> verif/vbr_ctrl_model.sv
// backplane controller model: register reads, writes and busy polling
`timescale 1ns/1ns
module vbr_ctrl_model (
  // clock
  input wire logic clk_i,
  // register access toward the bank
  output logic rd_o,
  output logic wr_o,
  output logic [2:0] addr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 3'h0;
    wdata_o = 16'h0000;
  end
  // one write; lines scrambled after release so stale data is never trusted
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // one read; data taken at the edge after the sampled one, where it stands
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  // bounded busy poll before the next command, so a stuck flag shows up
  task automatic wait_idle(output logic ok);
    logic [15:0] s;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      rd(3'h1, s);
      ok = (s[1] === 1'b0);
    end
  endtask
endmodule

// >>> verif/voltmeter_backplane_regs_tb_top.sv
// self-checking bench for the voltmeter backplane register bank
`timescale 1ns/1ns
module voltmeter_backplane_regs_tb_top;
  import vbr_pkg::*;
  localparam int RST_CYC = 8;
  localparam logic [7:0] ID = 8'hC3; // arbitrary identification value
  logic clk;
  logic rst_n;
  logic rd;
  logic wr;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic gen_irq;
  logic scan_irq;
  logic trig;
  logic chan;
  vbr_core_ev_t ev;
  logic autor;
  logic multi;
  logic trig_out;
  logic cmd_stb;
  logic [15:0] cmd;
  logic param_stb;
  logic [15:0] param;
  logic core_rst;
  logic [15:0] rv;
  logic [15:0] cmd_seen;
  logic [15:0] param_seen;
  logic ok;
  int error_cnt;
  int n_checks;
  int trig_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  vbr_regs #(.ID_CODE(ID), .RST_CYCLES(RST_CYC)) DUT (
    .CLK_I(clk), .NRST_I(rst_n), .RD_I(rd), .WR_I(wr), .ADDR_I(addr),
    .WDATA_I(wdata), .RDATA_O(rdata), .GENERAL_PURPOSE_IRQ_LINE_O(gen_irq),
    .NORMAL_SCAN_IRQ_LINE_O(scan_irq), .TRIG_I(trig), .CHANNEL_CLOSED_LINE_I(chan),
    .CORE_EV_I(ev), .AUTORANGE_I(autor),
    .MULTI_READ_I(multi), .TRIGGER_O(trig_out), .CMD_STB_O(cmd_stb), .CMD_O(cmd),
    .PARAM_STB_O(param_stb), .PARAM_O(param), .CORE_RST_O(core_rst));
  vbr_ctrl_model u_ctrl (.clk_i(clk), .rd_o(rd), .wr_o(wr), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // strobes are one cycle wide, so catch them every edge
  always @(posedge clk) begin
    if (trig_out === 1'b1) trig_cnt <= trig_cnt + 1;
    if (cmd_stb === 1'b1) cmd_seen <= cmd;
    if (param_stb === 1'b1) param_seen <= param;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // core event pulse, mask bits: result, error, run-up done, command done
  task automatic pulse(input logic [3:0] m, input logic [31:0] v);
    @(posedge clk);
    {ev.cmd_complete, ev.conv_done, ev.error_load, ev.result_load} <= m;
    ev.result <= v;
    ev.error_code <= v;
    @(posedge clk);
    {ev.cmd_complete, ev.conv_done, ev.error_load, ev.result_load} <= 4'h0;
    ev.result <= ~v;
    ev.error_code <= ~v;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_cmd();
    u_ctrl.rd(VBR_A_ID, rv);
    chk(rv, {8'h00, ID});
    u_ctrl.wr(VBR_A_CMD, 16'hA5C3);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0002);
    chk(cmd_seen, 16'hA5C3);
    pulse(4'h8, 32'h0);
    u_ctrl.wait_idle(ok);
    chk({ok, rv}, {1'b1, 16'h0002});
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0010);
    u_ctrl.wr(VBR_A_PARAM, 16'h3C5A);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0002);
    chk(param_seen, 16'h3C5A);
    pulse(4'h8, 32'h0);
  endtask
  // results, irq line choice, source choice and master enable
  task automatic t_res();
    u_ctrl.wr(VBR_A_CTRL, 16'h00F1);
    pulse(4'h1, 32'h12345678);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0011);
    chk({gen_irq, scan_irq}, 2'b10);
    u_ctrl.rd(VBR_A_RES_HI, rv);
    chk(rv, 16'h1234);
    pulse(4'h1, 32'hCAFEBABE);
    u_ctrl.rd(VBR_A_RES_LO, rv);
    chk(rv, 16'hBABE);
    u_ctrl.wr(VBR_A_RES_ACK, 16'h5555);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk({gen_irq, rv}, {1'b0, 16'h0010});
    pulse(4'h4, 32'h0);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk({gen_irq, scan_irq, rv}, {2'b00, 16'h0014});
    u_ctrl.wr(VBR_A_CTRL, 16'h000D);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk({gen_irq, scan_irq}, 2'b01);
    u_ctrl.wr(VBR_A_CONV_ACK, 16'hFFFF);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk({scan_irq, rv}, {1'b0, 16'h0010});
    u_ctrl.wr(VBR_A_CTRL, 16'h000C);
    pulse(4'h1, 32'h1);
    chk({gen_irq, scan_irq}, 2'b00);
  endtask
  // error code in the data words, aperiodic flag from core or mode pair
  task automatic t_err();
    pulse(4'h2, 32'h0000BEEF);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0019);
    u_ctrl.rd(VBR_A_RES_LO, rv);
    chk(rv, 16'hBEEF);
    @(posedge clk);
    ev.aperiodic <= 1'b1;
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0059);
    ev.aperiodic <= 1'b0;
    {autor, multi} <= 2'b11;
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0059);
    autor <= 1'b0;
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0019);
    multi <= 1'b0;
  endtask
  // each mode sees one trigger fall and one channel-closed rise
  task automatic t_trig();
    logic [1:0] md;
    int n;
    for (int k = 0; k < 4; k++) begin
      md = 2'(3 - k);
      u_ctrl.wr(VBR_A_TRIG, {14'h3FFC, md});
      n = trig_cnt;
      trig <= 1'b0;
      repeat (4) @(posedge clk);
      {trig, chan} <= 2'b11;
      repeat (4) @(posedge clk);
      chan <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(trig_cnt - n), {31'h0, md[0]});
    end
  endtask
  task automatic t_rst();
    int n;
    u_ctrl.wr(VBR_A_CTRL, 16'h0003);
    pulse(4'h1, 32'h1);
    chk({core_rst, gen_irq}, 2'b10);
    u_ctrl.wr(VBR_A_CTRL, 16'h0001);
    u_ctrl.rd(VBR_A_STATUS, rv);
    chk(rv, 16'h0002);
    for (n = 0; n < RST_CYC + 4 && core_rst !== 1'b0; n++) @(posedge clk);
    chk(core_rst, 1'b0);
    pulse(4'h8, 32'h0);
    u_ctrl.wait_idle(ok);
    chk(ok, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    {trig, chan, autor, multi} = 4'h8;
    ev = '0;
    {error_cnt, n_checks, trig_cnt} = '0;
    {cmd_seen, param_seen} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_cmd();
    t_res();
    t_err();
    t_trig();
    t_rst();
    print_verdict();
  end
  // hang guard, far above the couple of hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule
